// >>> hdl/pdc_regs.sv
/*
 pdc_regs: APB register bank for pins five to eight, the video/audio datapath
 options and the latched strap decodes; drives the pads and datapath controls.
 assumes: APB master per the protocol; pad and strap inputs are asynchronous;
 de_raw and the in-band audio signals come from logic on clk.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pdc_regs
	import pdc_pkg::*;
#(
	parameter int SETTLE_CYCLES = pdc_pkg::PDC_STRAP_SETTLE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pads for pins five to eight, index 0 is pin five
	input  wire logic [3:0]  pin_in,
	output logic      [3:0]  pin_out,
	output logic      [3:0]  pin_oe_n,
	output logic      [3:0]  pin_func_in,
	// strap decodes
	input  wire logic [pdc_pkg::PDC_STRAP_W-1:0] strap_a_pin,
	input  wire logic [pdc_pkg::PDC_STRAP_W-1:0] strap_b_pin,
	// datapath
	input  wire logic        de_raw,
	input  wire logic        repeater_mode,
	input  wire logic        inband_chb_valid,
	input  wire logic        inband_chb_enable,
	output logic             de_active,
	output logic             repeater_audio_regenerate,
	output logic             narrow_color_select,
	output logic             audio_frame_transport,
	output logic             chan_b_enable
);
	import pdc_pkg::*;

	logic [7:0] pins56_q;
	logic [7:0] pins78_q;
	logic [7:0] dpath_q;
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [PDC_STRAP_W-1:0] strap_a_value;
	logic [PDC_STRAP_W-1:0] strap_b_value;
	logic       strap_a_latched;
	logic       strap_b_latched;
	logic       pready_q;
	logic       pslverr_q;
	logic [31:0] prdata_q;
	logic       acc_first;
	logic       wr_fire;
	logic [9:0] idx;
	logic [7:0] rd_mux;
	logic [3:0] gp_out;
	logic [3:0] gp_in;

	// register index from a byte address
	function automatic logic [9:0] reg_index(input logic [11:0] a);
		reg_index = a[11:2];
	endfunction

	// address maps onto a register
	function automatic logic reg_hit(input logic [11:0] a);
		logic [9:0] i;
		i = reg_index(a);
		reg_hit = (a[1:0] == 2'b00) &&
			(i == PDC_IDX_PINS56 || i == PDC_IDX_PINS78 || i == PDC_IDX_DPATH ||
			i == PDC_IDX_STRAP || i == PDC_IDX_PIN_IN);
	endfunction

	// pad select field of pin n
	function automatic logic [1:0] pad_sel(input logic [7:0] r56, input logic [7:0] r78,
		input int n);
		logic [7:0] r;
		r = (n < 2) ? r56 : r78;
		pad_sel = (n % 2 == 0) ? r[PDC_PAD_LO +: 2] : r[PDC_PAD_HI +: 2];
	endfunction

	// drive level of pin n
	function automatic logic pad_lvl(input logic [7:0] r56, input logic [7:0] r78,
		input int n);
		logic [7:0] r;
		r = (n < 2) ? r56 : r78;
		pad_lvl = (n % 2 == 0) ? r[PDC_LVL_LO] : r[PDC_LVL_HI];
	endfunction

	assign idx       = reg_index(paddr);
	assign acc_first = psel && penable && !pready_q;
	assign wr_fire   = psel && penable && pready_q && pwrite && !pslverr_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign prdata    = prdata_q;

	// apb handshake, one wait state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= acc_first;
			pslverr_q <= acc_first && !reg_hit(paddr);
		end
	end

	// read mux
	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			PDC_IDX_PINS56: rd_mux = pins56_q & PDC_PIN_WMASK;
			PDC_IDX_PINS78: rd_mux = pins78_q & PDC_PIN_WMASK;
			PDC_IDX_DPATH:  rd_mux = dpath_q & PDC_DP_WMASK;
			PDC_IDX_STRAP: begin
				rd_mux[PDC_ST_B_DONE] = strap_b_latched;
				rd_mux[PDC_ST_B_VAL +: PDC_STRAP_W] = strap_b_value;
				rd_mux[PDC_ST_A_DONE] = strap_a_latched;
				rd_mux[PDC_ST_A_VAL +: PDC_STRAP_W] = strap_a_value;
			end
			PDC_IDX_PIN_IN: rd_mux = {4'h0, gp_in};
			default:        rd_mux = 8'h00;
		endcase
		if (paddr[1:0] != 2'b00) begin
			rd_mux = 8'h00;
		end
	end

	// read data capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (acc_first && !pwrite) begin
			prdata_q <= {24'h00_0000, rd_mux};
		end
	end

	// pin configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins56_q <= PDC_PIN_RST;
			pins78_q <= PDC_PIN_RST;
		end else if (wr_fire) begin
			if (idx == PDC_IDX_PINS56) begin
				pins56_q <= pwdata[7:0] & PDC_PIN_WMASK;
			end
			if (idx == PDC_IDX_PINS78) begin
				pins78_q <= pwdata[7:0] & PDC_PIN_WMASK;
			end
		end
	end

	// datapath control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dpath_q <= PDC_DP_RST;
		end else if (wr_fire && idx == PDC_IDX_DPATH) begin
			dpath_q <= pwdata[7:0] & PDC_DP_WMASK;
		end
	end

	// pad input synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// pad control per pin
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pad
			pdc_pad_t sel;
			assign sel = pdc_pad_t'(pad_sel(pins56_q, pins78_q, g));
			assign gp_out[g] = (sel == PDC_PAD_GP_OUT);
			assign pin_oe_n[g] = !gp_out[g];
			assign pin_out[g] = gp_out[g] & pad_lvl(pins56_q, pins78_q, g);
			assign gp_in[g] = (sel == PDC_PAD_GP_IN) & pin_sync_q[g];
			assign pin_func_in[g] = (sel == PDC_PAD_FUNC_IN) & pin_sync_q[g];
		end
	endgenerate

	// datapath outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			de_active                 <= 1'b0;
			repeater_audio_regenerate <= 1'b0;
			narrow_color_select       <= 1'b0;
			audio_frame_transport     <= 1'b0;
			chan_b_enable             <= 1'b0;
		end else begin
			de_active                 <= de_raw ^ dpath_q[PDC_DP_DE_INV];
			repeater_audio_regenerate <= dpath_q[PDC_DP_REGEN];
			narrow_color_select       <= dpath_q[PDC_DP_NARROW];
			audio_frame_transport     <= dpath_q[PDC_DP_FRAME_AUD];
			if (repeater_mode && inband_chb_valid) begin
				chan_b_enable <= inband_chb_enable;
			end else begin
				chan_b_enable <= dpath_q[PDC_DP_CHB_GATE] & dpath_q[PDC_DP_CHB_EN];
			end
		end
	end

	// strap latches
	pdc_strap_latch #(
		.WIDTH         (PDC_STRAP_W),
		.SETTLE_CYCLES (SETTLE_CYCLES)
	) u_strap_a (
		.clk       (clk),
		.rst_n     (rst_n),
		.strap_pin (strap_a_pin),
		.value_q   (strap_a_value),
		.done_q    (strap_a_latched)
	);

	pdc_strap_latch #(
		.WIDTH         (PDC_STRAP_W),
		.SETTLE_CYCLES (SETTLE_CYCLES)
	) u_strap_b (
		.clk       (clk),
		.rst_n     (rst_n),
		.strap_pin (strap_b_pin),
		.value_q   (strap_b_value),
		.done_q    (strap_b_latched)
	);

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_pad_decode;
		gp_out[0] == (pins56_q[1:0] == 2'b01) && gp_out[3] == (pins78_q[5:4] == 2'b01);
	endproperty
	a_pad_decode: assert property (p_pad_decode)
		else $error("pad select decode wrong");

	property p_pin6_write;
		wr_fire && idx == PDC_IDX_PINS56 && pwdata[5:4] == 2'b01
		|=> pin_oe_n[1] == 1'b0 && pin_out[1] == $past(pwdata[7]);
	endproperty
	a_pin6_write: assert property (p_pin6_write)
		else $error("pin six field placement wrong");

	property p_pin5_write;
		wr_fire && idx == PDC_IDX_PINS56 && pwdata[1:0] == 2'b01
		|=> pin_oe_n[0] == 1'b0 && pin_out[0] == $past(pwdata[3]);
	endproperty
	a_pin5_write: assert property (p_pin5_write)
		else $error("pin five field placement wrong");

	property p_pin8_write;
		wr_fire && idx == PDC_IDX_PINS78 && pwdata[5:4] == 2'b01
		|=> pin_oe_n[3] == 1'b0 && pin_out[3] == $past(pwdata[7]);
	endproperty
	a_pin8_write: assert property (p_pin8_write)
		else $error("pin eight field placement wrong");

	property p_pin7_write;
		wr_fire && idx == PDC_IDX_PINS78 && pwdata[1:0] == 2'b01
		|=> pin_oe_n[2] == 1'b0 && pin_out[2] == $past(pwdata[3]);
	endproperty
	a_pin7_write: assert property (p_pin7_write)
		else $error("pin seven field placement wrong");

	property p_no_drive;
		(pin_oe_n == ~gp_out) && ((pin_out & ~gp_out) == 4'h0);
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("pin driven outside output mode");

	property p_de_pol;
		##1 de_active == ($past(de_raw) ^ $past(dpath_q[PDC_DP_DE_INV]));
	endproperty
	a_de_pol: assert property (p_de_pol)
		else $error("data enable polarity wrong");

	property p_regen;
		wr_fire && idx == PDC_IDX_DPATH |=> ##1 repeater_audio_regenerate == $past(pwdata[4], 2);
	endproperty
	a_regen: assert property (p_regen)
		else $error("repeater audio source wrong");

	property p_chb_gate;
		!dpath_q[PDC_DP_CHB_GATE] && !(repeater_mode && inband_chb_valid) |=> !chan_b_enable;
	endproperty
	a_chb_gate: assert property (p_chb_gate)
		else $error("channel B not gated off");

	property p_narrow;
		wr_fire && idx == PDC_IDX_DPATH |=> ##1 narrow_color_select == $past(pwdata[2], 2);
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("color depth select wrong");

	property p_transport;
		wr_fire && idx == PDC_IDX_DPATH |=> ##1 audio_frame_transport == $past(pwdata[1], 2);
	endproperty
	a_transport: assert property (p_transport)
		else $error("audio transport select wrong");

	property p_chb_en;
		dpath_q[PDC_DP_CHB_GATE] && !(repeater_mode && inband_chb_valid)
		|=> chan_b_enable == $past(dpath_q[PDC_DP_CHB_EN]);
	endproperty
	a_chb_en: assert property (p_chb_en)
		else $error("channel B enable wrong");

	property p_inband;
		repeater_mode && inband_chb_valid |=> chan_b_enable == $past(inband_chb_enable);
	endproperty
	a_inband: assert property (p_inband)
		else $error("in-band override ignored");

	property p_b_done_hold;
		strap_b_latched |=> strap_b_latched && $stable(strap_b_value);
	endproperty
	a_b_done_hold: assert property (p_b_done_hold)
		else $error("strap B latch not held");

	property p_b_read;
		acc_first && !pwrite && paddr == {PDC_IDX_STRAP, 2'b00}
		|=> prdata_q[7:4] == $past({strap_b_latched, strap_b_value});
	endproperty
	a_b_read: assert property (p_b_read)
		else $error("strap B readback wrong");

	property p_a_done_hold;
		strap_a_latched |=> strap_a_latched && $stable(strap_a_value);
	endproperty
	a_a_done_hold: assert property (p_a_done_hold)
		else $error("strap A latch not held");

	property p_a_read;
		acc_first && !pwrite && paddr == {PDC_IDX_STRAP, 2'b00}
		|=> prdata_q[3:0] == $past({strap_a_latched, strap_a_value});
	endproperty
	a_a_read: assert property (p_a_read)
		else $error("strap A readback wrong");

	property p_reserved;
		(pins56_q & ~PDC_PIN_WMASK) == 8'h00 && (pins78_q & ~PDC_PIN_WMASK) == 8'h00 &&
		!dpath_q[7] && prdata_q[31:8] == 24'h00_0000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit not zero");

	property p_apb_wait;
		acc_first |=> pready_q ##1 !pready_q;
	endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("apb ready timing wrong");

endmodule
`default_nettype wire

// >>> hdl/pdc_pkg.sv
/*
 pdc_pkg: register indices, field positions, masks, reset values and timing counts
 for the pin and datapath configuration register bank.
 assumes: 125 MHz core clock; registers reached over APB, byte address = 4 * index.
*/
package pdc_pkg;

	// register indices, byte address = 4 * index
	localparam logic [9:0] PDC_IDX_PINS56  = 10'h010;
	localparam logic [9:0] PDC_IDX_PINS78  = 10'h011;
	localparam logic [9:0] PDC_IDX_DPATH   = 10'h012;
	localparam logic [9:0] PDC_IDX_STRAP   = 10'h013;
	localparam logic [9:0] PDC_IDX_PIN_IN  = 10'h020;

	// pin config fields, lower pin at 0, upper pin at 4
	localparam int PDC_PAD_LO   = 0;
	localparam int PDC_LVL_LO   = 3;
	localparam int PDC_PAD_HI   = 4;
	localparam int PDC_LVL_HI   = 7;
	localparam logic [7:0] PDC_PIN_WMASK = 8'hbb;
	localparam logic [7:0] PDC_PIN_RST   = 8'h00;

	// datapath fields
	localparam int PDC_DP_CHB_EN    = 0;
	localparam int PDC_DP_FRAME_AUD = 1;
	localparam int PDC_DP_NARROW    = 2;
	localparam int PDC_DP_CHB_GATE  = 3;
	localparam int PDC_DP_REGEN     = 4;
	localparam int PDC_DP_DE_INV    = 5;
	localparam logic [7:0] PDC_DP_WMASK = 8'h7f;
	localparam logic [7:0] PDC_DP_RST   = 8'h00;

	// strap status fields
	localparam int PDC_ST_A_VAL  = 0;
	localparam int PDC_ST_A_DONE = 3;
	localparam int PDC_ST_B_VAL  = 4;
	localparam int PDC_ST_B_DONE = 7;
	localparam int PDC_STRAP_W   = 3;

	// pad select encodings {dir, en}
	typedef enum logic [1:0] {
		PDC_PAD_FUNC_IN = 2'b00,
		PDC_PAD_GP_OUT  = 2'b01,
		PDC_PAD_TRI     = 2'b10,
		PDC_PAD_GP_IN   = 2'b11
	} pdc_pad_t;

	// timing
	localparam int PDC_CLK_PERIOD_NS   = 8;
	localparam int PDC_STRAP_SETTLE_NS = 1000;
	localparam int PDC_STRAP_SETTLE_CYC =
		(PDC_STRAP_SETTLE_NS + PDC_CLK_PERIOD_NS - 1) / PDC_CLK_PERIOD_NS;

endpackage

// >>> hdl/pdc_strap_latch.sv
/*
 pdc_strap_latch: samples one multi-bit strap decode, waits until it holds steady
 for a settle time, then latches it and raises a done flag until the next reset.
 assumes: strap input is asynchronous and static after power-up.
*/
`timescale 1ns/1ns
`default_nettype none
module pdc_strap_latch #(
	parameter int WIDTH         = 3,
	parameter int SETTLE_CYCLES = 125
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// strap
	input  wire logic [WIDTH-1:0] strap_pin,
	// result
	output logic      [WIDTH-1:0] value_q,
	output logic                  done_q
);
	typedef enum logic [1:0] {
		PDC_SL_WAIT   = 2'b00,
		PDC_SL_SETTLE = 2'b01,
		PDC_SL_DONE   = 2'b10
	} pdc_sl_state_t;

	generate
		if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 65535 || WIDTH < 1) begin : g_bad
			$error("pdc_strap_latch: parameters out of range");
		end
	endgenerate

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;
	logic [15:0]      cnt_q;
	pdc_sl_state_t    state_q;

	// two-flop synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= strap_pin;
			sync_q <= meta_q;
		end
	end

	// settle and latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PDC_SL_WAIT;
			prev_q  <= '0;
			cnt_q   <= '0;
			value_q <= '0;
			done_q  <= 1'b0;
		end else begin
			prev_q <= sync_q;
			case (state_q)
				PDC_SL_WAIT: begin
					cnt_q   <= '0;
					state_q <= PDC_SL_SETTLE;
				end
				PDC_SL_SETTLE: begin
					if (sync_q != prev_q) begin
						cnt_q <= '0;
					end else if (cnt_q == 16'(SETTLE_CYCLES - 1)) begin
						value_q <= sync_q;
						done_q  <= 1'b1;
						state_q <= PDC_SL_DONE;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				PDC_SL_DONE: begin
					state_q <= PDC_SL_DONE;
				end
				default: begin
					state_q <= PDC_SL_WAIT;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verification/pdc_testbench.sv
/*
 testbench: self-checking bench for pdc_regs; drives APB, pads, straps and datapath inputs.
 assumes: pdc_pkg and the design files are compiled first; straps are driven from time zero, and strap A is changed after it has latched.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pdc_pkg::*;

	localparam int SETTLE = 4;

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pin_in;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe_n;
	logic [3:0]  pin_func_in;
	logic [2:0]  strap_a_pin;
	logic [2:0]  strap_b_pin;
	logic        de_raw;
	logic        repeater_mode;
	logic        inband_chb_valid;
	logic        inband_chb_enable;
	logic        de_active;
	logic        repeater_audio_regenerate;
	logic        narrow_color_select;
	logic        audio_frame_transport;
	logic        chan_b_enable;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  m [2];
	int          err_count;
	int          tests_run;
	int          cyc = 0;

	pdc_regs #(.SETTLE_CYCLES(SETTLE)) dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_func_in(pin_func_in), .strap_a_pin(strap_a_pin), .strap_b_pin(strap_b_pin),
		.de_raw(de_raw), .repeater_mode(repeater_mode),
		.inband_chb_valid(inband_chb_valid), .inband_chb_enable(inband_chb_enable),
		.de_active(de_active), .repeater_audio_regenerate(repeater_audio_regenerate),
		.narrow_color_select(narrow_color_select),
		.audio_frame_transport(audio_frame_transport), .chan_b_enable(chan_b_enable)
	);

	always #4 clk = ~clk;

	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize;
		end
	end

	task summarize;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, waits for pready at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk(32'h1, 32'h0);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// pad outputs and readback against the bench copy of the pin registers
	task pads_chk;
		logic [3:0] oe, po, fi, rb;
		logic [1:0] s;
		int p;
		for (p = 0; p < 4; p++) begin
			s = m[p/2][(p%2)*4 +: 2];
			oe[p] = (s != 2'b01);
			po[p] = (s == 2'b01) & m[p/2][(p%2)*4+3];
			fi[p] = (s == 2'b00) & pin_in[p];
			rb[p] = (s == 2'b11) & pin_in[p];
		end
		chk(pin_oe_n, oe);
		chk(pin_out, po);
		chk(pin_func_in, fi);
		apb(1'b0, 12'h080, 8'h00);
		chk(rd, rb);
	endtask

	task t_reset;
		chk(pin_oe_n, 4'hf);
		chk(pin_out, 4'h0);
		apb(1'b0, 12'h04c, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, 12'h040, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, 12'h044, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, 12'h048, 8'h00);
		chk(rd, 32'h0);
	endtask

	// every pad code on every pin, level bit set, reserved bits written
	task t_pads;
		logic [7:0]  d;
		logic [11:0] a;
		int p, c, sh;
		for (p = 0; p < 4; p++) begin
			for (c = 0; c < 4; c++) begin
				sh = (p%2)*4;
				a = 12'h040 + 12'(4*(p/2));
				d = (m[p/2] & ~(8'h0f << sh)) | 8'(c << sh) | 8'(8 << sh) | 8'h44;
				apb(1'b1, a, d);
				chk(er, 1'b0);
				m[p/2] = d & 8'hbb;
				settle;
				pads_chk;
				apb(1'b0, a, 8'h00);
				chk(rd, m[p/2]);
			end
		end
		apb(1'b1, 12'h040, 8'h01);
		m[0] = 8'h01;
		settle;
		pads_chk;
		pin_in <= 4'h5;
		repeat (4) @(posedge clk);
		pads_chk;
	endtask

	// datapath values crossed with repeater and in-band inputs
	task t_dpath;
		logic [7:0] tbl [7];
		logic [7:0] v;
		logic [2:0] q;
		int i, k;
		tbl = '{8'hff, 8'h21, 8'h09, 8'h08, 8'h01, 8'h16, 8'h00};
		for (i = 0; i < 7; i++) begin
			v = tbl[i];
			apb(1'b1, 12'h048, v);
			chk(er, 1'b0);
			apb(1'b0, 12'h048, 8'h00);
			chk(rd, v & 8'h7f);
			for (k = 0; k < 8; k++) begin
				q = 3'(k);
				@(posedge clk);
				{repeater_mode, inband_chb_valid, inband_chb_enable} <= q;
				de_raw <= q[0];
				settle;
				chk(de_active, q[0] ^ v[5]);
				chk(repeater_audio_regenerate, v[4]);
				chk(narrow_color_select, v[2]);
				chk(audio_frame_transport, v[1]);
				chk(chan_b_enable, (q[2] & q[1]) ? q[0] : v[3] & v[0]);
			end
		end
	endtask

	task t_err;
		apb(1'b0, 12'h0fc, 8'h00);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h041, 8'hff);
		chk(er, 1'b1);
		apb(1'b0, 12'h040, 8'h00);
		chk(rd, m[0]);
	endtask

	task t_strap;
		repeat (20) @(posedge clk);
		apb(1'b0, 12'h04c, 8'h00);
		chk(rd, 32'had);
		strap_a_pin <= 3'h2;
		apb(1'b1, 12'h04c, 8'h00);
		chk(er, 1'b0);
		repeat (20) @(posedge clk);
		apb(1'b0, 12'h04c, 8'h00);
		chk(rd, 32'had);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pin_in = 4'ha;
		strap_a_pin = 3'h5;
		strap_b_pin = 3'h2;
		de_raw = 1'b0;
		repeater_mode = 1'b0;
		inband_chb_valid = 1'b0;
		inband_chb_enable = 1'b0;
		err_count = 0;
		tests_run = 0;
		m[0] = 8'h00;
		m[1] = 8'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		t_reset;
		t_pads;
		t_dpath;
		t_err;
		t_strap;
		summarize;
	end
endmodule
`default_nettype wire
